//--- src/crs_core_regs.sv
`timescale 1ns/1ns
module crs_core_regs #(
    parameter int unsigned NUM_GPR = crs_pkg::GPR_N
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // general register ports
    input crs_pkg::crs_gpr_wr_t gpr_wr,
    input wire logic [3:0] rd_a_idx,
    input wire logic [3:0] rd_b_idx,
    output logic [15:0] rd_a_data,
    output logic [15:0] rd_b_data,
    // address registers from the core
    input wire logic pc_load,
    input wire logic [20:0] pc_next,
    input wire logic isp_load,
    input wire logic [20:0] isp_next,
    input wire logic base_load,
    input wire logic [20:0] base_next,
    output logic [20:0] program_counter,
    output logic [20:0] interrupt_stack_ptr,
    output logic [20:0] dispatch_table_base,
    output logic isp_out_of_range,
    // flag updates
    input crs_pkg::crs_alu_req_t alu_req,
    input wire logic f_set_valid,
    input wire logic f_set_value,
    // instruction and exception events
    input wire logic instr_retire,
    input wire logic enable_irq_instr,
    input wire logic mask_off_instr,
    input wire logic irq_taken,
    input wire logic trap_taken,
    input wire logic isr_return,
    output logic [15:0] processor_status_word,
    output logic maskable_irq_ok,
    output logic trace_trap_req,
    // address forming
    input wire logic mem_req,
    input wire logic mem_is_load_store,
    input wire logic [15:0] disp,
    output logic mem_addr_valid,
    output logic [20:0] rel_addr,
    output logic [20:0] branch_target,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    if (NUM_GPR != 16) begin : g_chk
        $error("crs_core_regs: register index is four bits, NUM_GPR must be 16");
    end

    logic [15:0] gpr_q [NUM_GPR];
    logic [20:0] pc_q;
    logic [20:0] isp_q;
    logic [20:0] base_q;
    logic [15:0] psr_q;
    logic [15:0] psr_d;
    logic [15:0] cfg_q;
    crs_pkg::crs_flags_t flags;

    // bus write and read channel state
    logic aw_q;
    logic w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic bus_wr;
    logic wr_hit;
    logic [15:0] wr_lo;
    logic gpr_sel;
    logic [3:0] wr_gidx;

    crs_flag_unit u_flags (
        .req(alu_req),
        .flags(flags)
    );

    // merge byte lanes over the current value
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                               input logic [3:0] strb);
        lane_merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction : lane_merge

    function automatic logic [20:0] addr_merge(input logic [20:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        addr_merge = {strb[2] ? nw[20:16] : old[20:16], strb[1] ? nw[15:8] : old[15:8],
                      strb[0] ? nw[7:0] : old[7:0]};
    endfunction : addr_merge

    // ---------------- write channel ----------------
    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready = !w_q && !bvalid_q;
    assign bus_wr = aw_q && w_q && !bvalid_q;
    assign gpr_sel = awaddr_q[7:6] == crs_pkg::OFS_GPR[7:6];
    assign wr_gidx = awaddr_q[5:2];
    assign wr_lo = wdata_q[15:0];
    assign wr_hit = gpr_sel || awaddr_q == crs_pkg::OFS_PC || awaddr_q == crs_pkg::OFS_ISP ||
                    awaddr_q == crs_pkg::OFS_BASE || awaddr_q == crs_pkg::OFS_PSR ||
                    awaddr_q == crs_pkg::OFS_CFG;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            aw_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (bus_wr) begin
            aw_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            w_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (bus_wr) begin
            w_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bvalid_q <= 1'b0;
            bresp_q <= crs_pkg::RESP_OK;
        end else if (bus_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? crs_pkg::RESP_OK : crs_pkg::RESP_ERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ---------------- general registers ----------------
    // a core write in the same cycle as a bus write to the same register wins
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            gpr_q[0] <= pc_q[16:1];
            gpr_q[1] <= psr_q;
        end else begin
            if (bus_wr && gpr_sel) begin
                gpr_q[wr_gidx] <= lane_merge(gpr_q[wr_gidx], wr_lo, wstrb_q);
            end
            if (gpr_wr.en) begin
                if (gpr_wr.byte_only) begin
                    gpr_q[gpr_wr.idx] <= {gpr_q[gpr_wr.idx][15:8], gpr_wr.data[7:0]};
                end else begin
                    gpr_q[gpr_wr.idx] <= gpr_wr.data;
                end
            end
        end
    end

    assign rd_a_data = gpr_q[rd_a_idx];
    assign rd_b_data = gpr_q[rd_b_idx];

    // ---------------- dedicated address registers ----------------

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pc_q <= crs_pkg::ADDR_RESET;
        end else if (pc_load) begin
            pc_q <= pc_next & crs_pkg::ADDR_MASK;
        end else if (bus_wr && awaddr_q == crs_pkg::OFS_PC) begin
            pc_q <= addr_merge(pc_q, wdata_q, wstrb_q) & crs_pkg::ADDR_MASK;
        end
    end

    // reset value of the stack pointer is a choice; software sets it first
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            isp_q <= crs_pkg::ADDR_RESET;
        end else if (isp_load) begin
            isp_q <= isp_next & crs_pkg::ADDR_MASK;
        end else if (bus_wr && awaddr_q == crs_pkg::OFS_ISP) begin
            isp_q <= addr_merge(isp_q, wdata_q, wstrb_q) & crs_pkg::ADDR_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            base_q <= crs_pkg::ADDR_RESET;
        end else if (base_load) begin
            base_q <= base_next & crs_pkg::ADDR_MASK;
        end else if (bus_wr && awaddr_q == crs_pkg::OFS_BASE) begin
            base_q <= addr_merge(base_q, wdata_q, wstrb_q) & crs_pkg::ADDR_MASK;
        end
    end

    // the range check only reports; the core decides whether to trap on it
    assign isp_out_of_range = isp_q < crs_pkg::ISP_LO || isp_q > crs_pkg::ISP_HI;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cfg_q <= crs_pkg::CFG_RESET;
        end else if (bus_wr && awaddr_q == crs_pkg::OFS_CFG) begin
            cfg_q <= lane_merge(cfg_q, wr_lo, wstrb_q);
        end
    end

    // ---------------- status word ----------------
    // bus write first, hardware events after so that an event is never lost
    always_comb begin
        psr_d = psr_q;
        if (bus_wr && awaddr_q == crs_pkg::OFS_PSR) begin
            psr_d = lane_merge(psr_q, wr_lo, wstrb_q);
        end
        if (alu_req.valid && alu_req.op != crs_pkg::CRS_OP_CMP) begin
            psr_d[crs_pkg::PSR_C] = flags.c;
            psr_d[crs_pkg::PSR_F] = flags.f;
        end
        if (alu_req.valid && alu_req.op == crs_pkg::CRS_OP_CMP) begin
            psr_d[crs_pkg::PSR_L] = flags.l;
            psr_d[crs_pkg::PSR_Z] = flags.z;
            psr_d[crs_pkg::PSR_N] = flags.n;
        end
        if (f_set_valid) begin
            psr_d[crs_pkg::PSR_F] = f_set_value;
        end
        if (enable_irq_instr) begin
            psr_d[crs_pkg::PSR_E] = 1'b1;
        end
        if (mask_off_instr) begin
            psr_d[crs_pkg::PSR_E] = 1'b0;
        end
        // one pending trap per instruction: set only while none is pending
        if (instr_retire && psr_q[crs_pkg::PSR_T] && !psr_q[crs_pkg::PSR_P]) begin
            psr_d[crs_pkg::PSR_P] = 1'b1;
        end
        if (isr_return) begin
            psr_d[crs_pkg::PSR_I] = 1'b1;
        end
        if (irq_taken || trap_taken) begin
            psr_d[crs_pkg::PSR_T] = 1'b0;
            psr_d[crs_pkg::PSR_P] = 1'b0;
        end
        if (irq_taken) begin
            psr_d[crs_pkg::PSR_I] = 1'b0;
        end
        psr_d = psr_d & crs_pkg::PSR_MASK;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            psr_q <= crs_pkg::PSR_RESET;
        end else begin
            psr_q <= psr_d;
        end
    end

    assign maskable_irq_ok = psr_q[crs_pkg::PSR_E] && psr_q[crs_pkg::PSR_I];
    assign trace_trap_req = psr_q[crs_pkg::PSR_P];

    // ---------------- address forming ----------------
    assign mem_addr_valid = mem_req && mem_is_load_store;
    assign rel_addr = {5'h00, rd_a_data + disp};
    assign branch_target = (pc_q + {5'h00, disp}) & crs_pkg::ADDR_MASK;

    assign program_counter = pc_q;
    assign interrupt_stack_ptr = isp_q;
    assign dispatch_table_base = base_q;
    assign processor_status_word = psr_q;

    // ---------------- read channel ----------------
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= crs_pkg::RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= crs_pkg::RESP_OK;
            if (s_axi_araddr[7:6] == crs_pkg::OFS_GPR[7:6]) begin
                rdata_q <= {16'h0000, gpr_q[s_axi_araddr[5:2]]};
            end else begin
                case (s_axi_araddr)
                    crs_pkg::OFS_PC: rdata_q <= {11'h000, pc_q};
                    crs_pkg::OFS_ISP: rdata_q <= {11'h000, isp_q};
                    crs_pkg::OFS_BASE: rdata_q <= {11'h000, base_q};
                    crs_pkg::OFS_PSR: rdata_q <= {16'h0000, psr_q};
                    crs_pkg::OFS_CFG: rdata_q <= {16'h0000, cfg_q};
                    default: begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= crs_pkg::RESP_ERR;
                    end
                endcase
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule : crs_core_regs

//--- src/crs_pkg.sv
// Summary of operation
// - gprs, status, config 16 bits; addresses 21
// - reserved bits written zero, read undefined
// - sixteen gprs; byte writes keep high byte
// - pc even, top five bits zero
// - reset copies pc bits 16:1 to gpr0
// - isp aligned, stack within e000-e7ff; code does not enforce the range, only flags it on isp_out_of_range
// - dispatch base top five, bit0 zero
// - fixed status word bit layout
// - carry set on add/sub carry or borrow
// - trace traps each instruction; traps clear trace
// - unsigned compare sets low flag
// - flag bit marks add/sub overflow
// - compare equal sets zero flag
// - signed compare sets negative flag
// - maskable interrupts need both enables set
// - enable/disable instructions drive local enable
// - pending bit limits one trace trap
// - interrupt clears global enable; return sets
// - reset saves status to gpr1, sets local enable
// - only loads/stores touch memory operands
// - relative and branch addresses add displacement
package crs_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 21;
    localparam int unsigned GPR_N = 16;
    // status word bit positions
    localparam int unsigned PSR_C = 0;
    localparam int unsigned PSR_T = 1;
    localparam int unsigned PSR_L = 2;
    localparam int unsigned PSR_F = 5;
    localparam int unsigned PSR_Z = 6;
    localparam int unsigned PSR_N = 7;
    localparam int unsigned PSR_E = 9;
    localparam int unsigned PSR_P = 10;
    localparam int unsigned PSR_I = 11;
    localparam logic [15:0] PSR_MASK = 16'h0ee7;
    localparam logic [15:0] PSR_RESET = 16'h0200;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [20:0] ADDR_MASK = 21'h0_fffe;
    localparam logic [20:0] ADDR_RESET = 21'h0_0000;
    localparam logic [20:0] ISP_LO = 21'h0_e000;
    localparam logic [20:0] ISP_HI = 21'h0_e7ff;
    // bus map, byte addresses
    localparam logic [7:0] OFS_PC = 8'h00;
    localparam logic [7:0] OFS_ISP = 8'h04;
    localparam logic [7:0] OFS_BASE = 8'h08;
    localparam logic [7:0] OFS_PSR = 8'h0c;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam logic [7:0] OFS_GPR = 8'h40;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef enum logic [1:0] {
        CRS_OP_ADD = 2'b00,
        CRS_OP_SUB = 2'b01,
        CRS_OP_CMP = 2'b10
    } crs_op_t;

    typedef struct packed {
        logic en;
        logic byte_only;
        logic [3:0] idx;
        logic [15:0] data;
    } crs_gpr_wr_t;

    typedef struct packed {
        logic valid;
        crs_op_t op;
        logic [15:0] dst;
        logic [15:0] src;
        logic carry_in;
    } crs_alu_req_t;

    typedef struct packed {
        logic c;
        logic f;
        logic l;
        logic z;
        logic n;
    } crs_flags_t;
endpackage : crs_pkg

//--- src/crs_flag_unit.sv
`timescale 1ns/1ns
module crs_flag_unit (
    // operation
    input crs_pkg::crs_alu_req_t req,
    // result flags
    output crs_pkg::crs_flags_t flags
);
    logic [16:0] sum;
    logic [16:0] diff;

    assign sum = {1'b0, req.dst} + {1'b0, req.src} + {16'h0000, req.carry_in};
    assign diff = {1'b0, req.dst} - {1'b0, req.src} - {16'h0000, req.carry_in};

    always_comb begin
        flags = '0;
        case (req.op)
            crs_pkg::CRS_OP_ADD: begin
                flags.c = sum[16];
                flags.f = (req.dst[15] == req.src[15]) && (sum[15] != req.dst[15]);
            end
            crs_pkg::CRS_OP_SUB: begin
                flags.c = diff[16];
                flags.f = (req.dst[15] != req.src[15]) && (diff[15] != req.dst[15]);
            end
            crs_pkg::CRS_OP_CMP: begin
                flags.l = req.dst < req.src;
                flags.z = req.dst == req.src;
                flags.n = $signed(req.dst) < $signed(req.src);
            end
            default: flags = '0;
        endcase
    end
endmodule : crs_flag_unit

//--- tb/crs_core_model.sv
`timescale 1ns/1ns
module crs_core_model (
    // event code from the bench, one event a cycle
    input wire logic [2:0] evt,
    // pulses toward the register set
    output logic instr_retire,
    output logic enable_irq_instr,
    output logic mask_off_instr,
    output logic irq_taken,
    output logic trap_taken,
    output logic isr_return
);
    // the sequencer never touches the config word, which stays zero
    assign instr_retire = (evt == 3'h1);
    assign enable_irq_instr = (evt == 3'h2);
    assign mask_off_instr = (evt == 3'h3);
    assign irq_taken = (evt == 3'h4);
    assign trap_taken = (evt == 3'h5);
    assign isr_return = (evt == 3'h6);
endmodule : crs_core_model

//--- tb/crs_core_regs_asserts.sv
`timescale 1ns/1ns
module crs_core_regs_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // core requests
    input crs_pkg::crs_alu_req_t alu_req,
    input wire logic instr_retire,
    input wire logic enable_irq_instr,
    input wire logic mask_off_instr,
    input wire logic irq_taken,
    input wire logic trap_taken,
    input wire logic isr_return,
    // register outputs
    input wire logic [15:0] processor_status_word,
    input wire logic maskable_irq_ok,
    input wire logic trace_trap_req,
    input wire logic [20:0] program_counter,
    input wire logic [20:0] interrupt_stack_ptr,
    input wire logic [20:0] dispatch_table_base
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_addr_aligned:
        assert property (((program_counter | interrupt_stack_ptr | dispatch_table_base)
            & ~crs_pkg::ADDR_MASK) == 21'h0_0000) else $error("address register misaligned");
    a_psr_layout:
        assert property ((processor_status_word & ~crs_pkg::PSR_MASK) == 16'h0000)
            else $error("status fixed bits not zero");
    a_reset_state:
        assert property ($rose(rst_b) |-> processor_status_word == crs_pkg::PSR_RESET
            && program_counter == 21'h0_0000) else $error("state after reset wrong");
    a_carry_flag:
        assert property (alu_req.valid && alu_req.op != crs_pkg::CRS_OP_CMP && !alu_req.carry_in
            |=> processor_status_word[0] == (($past(alu_req.op) == crs_pkg::CRS_OP_SUB) ?
            ($past(alu_req.dst) < $past(alu_req.src)) : ($past(alu_req.dst) > ~$past(alu_req.src))))
            else $error("carry flag wrong");
    a_cmp_flags:
        assert property (alu_req.valid && alu_req.op == crs_pkg::CRS_OP_CMP |=>
            processor_status_word[2] == ($past(alu_req.dst) < $past(alu_req.src)) &&
            processor_status_word[6] == ($past(alu_req.dst) == $past(alu_req.src)) &&
            processor_status_word[7] == ($signed($past(alu_req.dst)) < $signed($past(alu_req.src))))
            else $error("compare flags wrong");
    a_irq_entry:
        assert property (irq_taken |=> (processor_status_word & 16'h0c02) == 16'h0000)
            else $error("interrupt entry left enables set");
    a_trap_entry:
        assert property (trap_taken |=> !processor_status_word[1] && !trace_trap_req)
            else $error("trap entry left trace set");
    a_irq_return:
        assert property (isr_return && !irq_taken |=> processor_status_word[11])
            else $error("return did not restore global enable");
    a_local_enable:
        assert property (enable_irq_instr || mask_off_instr |=>
            processor_status_word[9] == !$past(mask_off_instr)) else $error("local enable wrong");
    a_trace_pend:
        assert property (instr_retire && processor_status_word[1] && !trap_taken && !irq_taken
            |=> trace_trap_req) else $error("trace trap not pending");
    a_irq_gate:
        assert property (maskable_irq_ok == (processor_status_word[9] && processor_status_word[11]))
            else $error("maskable gate wrong");
    cover property (irq_taken);
    cover property (alu_req.valid && alu_req.op == crs_pkg::CRS_OP_CMP);
    cover property (instr_retire && trace_trap_req);
endmodule : crs_core_regs_asserts
bind crs_core_regs crs_core_regs_asserts crs_core_regs_asserts_i (.*);

//--- tb/test_cpu_core_register_set.sv
`timescale 1ns/1ns
module test_cpu_core_register_set;
    logic clock = 1'b0;
    logic rst_b, pc_load, isp_load, base_load, f_set_valid, f_set_value, mem_req;
    logic instr_retire, enable_irq_instr, mask_off_instr, irq_taken, trap_taken, isr_return;
    logic mem_is_load_store, mem_addr_valid, isp_out_of_range, maskable_irq_ok, trace_trap_req;
    logic [3:0] rd_a_idx, rd_b_idx, s_axi_wstrb;
    logic [15:0] rd_a_data, rd_b_data, disp, processor_status_word;
    logic [20:0] pc_next, isp_next, base_next, program_counter, interrupt_stack_ptr;
    logic [20:0] dispatch_table_base, rel_addr, branch_target;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    crs_pkg::crs_gpr_wr_t gpr_wr;
    crs_pkg::crs_alu_req_t alu_req;
    logic [2:0] evt;
    int miscompares = 0;
    int num_checks = 0;
    // add/sub cases hit carry, borrow and both overflow signs; compares hit each flag
    logic [1:0] ops [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [15:0] ds [7] = '{16'hffff, 16'h7fff, 16'h0000, 16'h8000, 16'h0001, 16'h8000, 16'h1234};
    logic [15:0] ss [7] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0002, 16'h0001, 16'h1234};

    crs_core_regs crs_core_regs_i (.*);
    crs_core_model crs_core_model_i (.*);

    always #4 clock = ~clock;

    function automatic logic [15:0] exp_flags(input logic [15:0] p, input logic [1:0] op,
                                              input logic [15:0] d, input logic [15:0] s);
        logic [16:0] r;
        r = (op == 2'h1) ? {1'b0, d} - {1'b0, s} : {1'b0, d} + {1'b0, s};
        if (op == 2'h2) begin
            p[2] = d < s;
            p[6] = d == s;
            p[7] = $signed(d) < $signed(s);
        end else begin
            p[0] = r[16];
            p[5] = ((d[15] ^ s[15]) == (op == 2'h1)) && (r[15] != d[15]);
        end
        return p;
    endfunction : exp_flags

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // drop every core pulse at the next edge, then let that edge's updates land
    task automatic settle;
        @(posedge clock);
        evt <= 3'h0;
        alu_req.valid <= 1'b0;
        gpr_wr.en <= 1'b0;
        pc_load <= 1'b0;
        isp_load <= 1'b0;
        base_load <= 1'b0;
        f_set_valid <= 1'b0;
        #1;
    endtask : settle

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        chk("rdata", e, s_axi_rdata);
    endtask : axi_rd

    task automatic fire(input logic [2:0] code, input logic [15:0] e);
        @(posedge clock);
        evt <= code;
        settle;
        chk("psr", 32'(e), 32'(processor_status_word));
    endtask : fire

    task automatic t_flags;
        logic [15:0] p;
        p = crs_pkg::PSR_RESET;
        for (int i = 0; i < 7; i++) begin
            @(posedge clock);
            alu_req <= '{1'b1, crs_pkg::crs_op_t'(ops[i]), ds[i], ss[i], 1'b0};
            settle;
            p = exp_flags(p, ops[i], ds[i], ss[i]);
            chk("flags", 32'(p), 32'(processor_status_word));
        end
        @(posedge clock);
        f_set_valid <= 1'b1;
        settle;
        p[crs_pkg::PSR_F] = 1'b1;
        chk("flag set", 32'(p), 32'(processor_status_word));
    endtask : t_flags

    task automatic t_gpr;
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            gpr_wr <= '{1'b1, 1'b0, 4'(i), 16'(i * 16'h1111)};
            settle;
        end
        @(posedge clock);
        gpr_wr <= '{1'b1, 1'b1, 4'h5, 16'hff7e};
        settle;
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            rd_a_idx <= 4'(i);
            #1;
            chk("gpr", (i == 5) ? 32'h0000_557e : 32'(i * 16'h1111), 32'(rd_a_data));
        end
        axi_rd(8'h7c, 32'h0000_ffff, crs_pkg::RESP_OK);
        axi_wr(8'h4c, 32'h0000_abcd, crs_pkg::RESP_OK);
        rd_b_idx <= 4'h3;
        #1;
        chk("gpr bus", 32'h0000_abcd, 32'(rd_b_data));
    endtask : t_gpr

    task automatic t_addr;
        @(posedge clock);
        pc_load <= 1'b1;
        pc_next <= 21'h1f_ffff;
        isp_load <= 1'b1;
        isp_next <= 21'h1f_e7ff;
        base_load <= 1'b1;
        base_next <= 21'h1f_ffff;
        settle;
        chk("pc", 32'h0000_fffe, 32'(program_counter));
        chk("base", 32'h0000_fffe, 32'(dispatch_table_base));
        chk("isp", 32'h0000_e7fe, 32'(interrupt_stack_ptr));
        chk("isp range", 32'h0, 32'(isp_out_of_range));
        @(posedge clock);
        isp_load <= 1'b1;
        isp_next <= 21'h0_e800;
        settle;
        chk("isp range", 32'h1, 32'(isp_out_of_range));
        axi_wr(crs_pkg::OFS_BASE, 32'h001f_1235, crs_pkg::RESP_OK);
        axi_rd(crs_pkg::OFS_BASE, 32'h0000_1234, crs_pkg::RESP_OK);
        // gpr5 holds 557e; the sum wraps inside 64k
        @(posedge clock);
        rd_a_idx <= 4'h5;
        disp <= 16'hb004;
        mem_req <= 1'b1;
        mem_is_load_store <= 1'b0;
        #1;
        chk("rel", 32'h0000_0582, 32'(rel_addr));
        chk("branch", 32'h0000_b002, 32'(branch_target));
        chk("mem valid", 32'h0, 32'(mem_addr_valid));
        @(posedge clock);
        mem_is_load_store <= 1'b1;
        #1;
        chk("mem valid", 32'h1, 32'(mem_addr_valid));
    endtask : t_addr

    task automatic t_events;
        axi_wr(crs_pkg::OFS_PSR, 32'h0000_0202, crs_pkg::RESP_OK);
        fire(3'h6, 16'h0a02);
        chk("irq ok", 32'h1, 32'(maskable_irq_ok));
        fire(3'h1, 16'h0e02);
        fire(3'h1, 16'h0e02);
        chk("trace req", 32'h1, 32'(trace_trap_req));
        fire(3'h5, 16'h0a00);
        axi_wr(crs_pkg::OFS_PSR, 32'h0000_0a02, crs_pkg::RESP_OK);
        fire(3'h4, 16'h0200);
        chk("irq ok", 32'h0, 32'(maskable_irq_ok));
        fire(3'h6, 16'h0a00);
        fire(3'h3, 16'h0800);
        chk("irq ok", 32'h0, 32'(maskable_irq_ok));
        fire(3'h2, 16'h0a00);
    endtask : t_events

    task automatic t_bus_and_reset;
        axi_wr(8'hfc, 32'h0000_0000, crs_pkg::RESP_ERR);
        axi_rd(8'hfc, 32'h0000_0000, crs_pkg::RESP_ERR);
        axi_rd(crs_pkg::OFS_CFG, 32'h0000_0000, crs_pkg::RESP_OK);
        axi_wr(crs_pkg::OFS_PSR, 32'h0000_0a25, crs_pkg::RESP_OK);
        @(posedge clock);
        pc_load <= 1'b1;
        pc_next <= 21'h0_1234;
        settle;
        // a single reset edge, so the captures see the old values
        @(posedge clock);
        rst_b <= 1'b0;
        @(posedge clock);
        rst_b <= 1'b1;
        rd_a_idx <= 4'h0;
        rd_b_idx <= 4'h1;
        #1;
        chk("pc capture", 32'h0000_091a, 32'(rd_a_data));
        chk("psr capture", 32'h0000_0a25, 32'(rd_b_data));
        chk("psr reset", 32'h0000_0200, 32'(processor_status_word));
        chk("pc reset", 32'h0, 32'(program_counter));
    endtask : t_bus_and_reset

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        rst_b = 1'b0;
        {pc_load, isp_load, base_load, f_set_valid, mem_req, mem_is_load_store} = 6'h00;
        f_set_value = 1'b1;
        {pc_next, isp_next, base_next} = '0;
        {rd_a_idx, rd_b_idx, disp, evt} = '0;
        gpr_wr = '0;
        alu_req = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        t_flags;
        t_gpr;
        t_addr;
        t_events;
        t_bus_and_reset;
        tally_and_finish;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        tally_and_finish;
    end
endmodule : test_cpu_core_register_set
